// ---- bootl_consts.svh ----
`ifndef BOOTL_CONSTS_SVH
`define BOOTL_CONSTS_SVH

// Markers found in the first stored byte
`define BOOTL_MARK_ID         8'hb4
`define BOOTL_MARK_CODE       8'hd2
// Serial memory read command and start address
`define BOOTL_CMD_READ        8'h03
`define BOOTL_START_ADDR      16'h0000
// Byte positions counted from the marker byte
`define BOOTL_IDX_MARK        0
`define BOOTL_IDX_VID_LO      1
`define BOOTL_IDX_VID_HI      2
`define BOOTL_IDX_PID_LO      3
`define BOOTL_IDX_PID_HI      4
`define BOOTL_IDX_REL_LO      5
`define BOOTL_IDX_REL_HI      6
`define BOOTL_IDX_LEN_LO      1
`define BOOTL_IDX_LEN_HI      2
`define BOOTL_IDX_CODE0       3
// Timing
`define BOOTL_MEM_PERIOD_NS   333
`define BOOTL_LINK_PERIOD_NS  6
`define BOOTL_HALF_CYC        ((`BOOTL_MEM_PERIOD_NS / 2 + `BOOTL_LINK_PERIOD_NS - 1) / `BOOTL_LINK_PERIOD_NS)
`define BOOTL_STRAP_WAIT      3

`endif

// ---- bootl_pkg.sv ----
package bootl_pkg;

  typedef enum logic [2:0] {
    BOOTL_S_IDLE = 3'b000,
    BOOTL_S_REQ  = 3'b001,
    BOOTL_S_WAIT = 3'b011,
    BOOTL_S_EVAL = 3'b010,
    BOOTL_S_DONE = 3'b110
  } bootl_state_t;

  typedef enum logic [1:0] {
    BOOTL_E_IDLE = 2'b00,
    BOOTL_E_LOW  = 2'b01,
    BOOTL_E_HIGH = 2'b11
  } bootl_eng_state_t;

endpackage : bootl_pkg

// ---- bootl_link_if.sv ----
`timescale 1ns/1ps
interface bootl_link_if;
  logic       req_tgl;
  logic       hold;
  logic       wide;
  logic       ack_tgl;
  logic [7:0] data;

  modport ctrl (output req_tgl, output hold, output wide, input ack_tgl, input data);
  modport eng  (input req_tgl, input hold, input wide, output ack_tgl, output data);
endinterface : bootl_link_if

// ---- bootl_spi_engine.sv ----
`timescale 1ns/1ps
`include "bootl_consts.svh"
module bootl_spi_engine (
  // Link clock and reset
  input  wire logic   link_clk_in,
  input  wire logic   resetn_in,
  // Controller side
  bootl_link_if.eng   lnk,
  // Memory pins
  input  wire logic   mem_data_in,
  output logic        boot_sclk_out,
  output logic        boot_serial_out,
  output logic        mem_cs_n_out
);
  localparam int HALF = (`BOOTL_HALF_CYC < 1) ? 1 : `BOOTL_HALF_CYC;
  localparam logic [7:0]  CMD_RD     = `BOOTL_CMD_READ;
  localparam logic [15:0] START_ADDR = `BOOTL_START_ADDR;

  bootl_pkg::bootl_eng_state_t st_q;
  logic [2:0]  req_s_q;
  logic [1:0]  hold_s_q;
  logic [1:0]  wide_s_q;
  logic [1:0]  din_s_q;
  logic [31:0] tx_q;
  logic [7:0]  rx_q;
  logic [5:0]  bits_q;
  logic [7:0]  div_q;
  logic        ack_q;
  logic [7:0]  data_q;

  wire       req_edge = req_s_q[2] ^ req_s_q[1];
  wire       half_end = (div_q == 8'(HALF - 1));
  // 9-bit parts take address bit 8 inside the command byte
  wire [31:0] hdr_narrow = {CMD_RD | {4'h0, START_ADDR[8], 3'h0}, START_ADDR[7:0], 16'h0000};
  wire [31:0] hdr_wide   = {CMD_RD, START_ADDR, 8'h00};
  wire [31:0] hdr_sel    = wide_s_q[1] ? hdr_wide : hdr_narrow; // R4 R13
  // Header plus the first data byte in one pass
  wire [5:0]  hdr_bits   = wide_s_q[1] ? 6'h20 : 6'h18;

  assign lnk.ack_tgl = ack_q;
  assign lnk.data    = data_q;

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_s_q  <= 3'h0;
      hold_s_q <= 2'h0;
      wide_s_q <= 2'h0;
      din_s_q  <= 2'h0;
    end else begin
      req_s_q  <= {req_s_q[1:0], lnk.req_tgl};
      hold_s_q <= {hold_s_q[0], lnk.hold};
      wide_s_q <= {wide_s_q[0], lnk.wide};
      din_s_q  <= {din_s_q[0], mem_data_in}; // R2
    end
  end

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q            <= bootl_pkg::BOOTL_E_IDLE;
      tx_q            <= 32'h0;
      rx_q            <= 8'h00;
      bits_q          <= 6'h0;
      div_q           <= 8'h00;
      ack_q           <= 1'b0;
      data_q          <= 8'h00;
      boot_sclk_out   <= 1'b0;
      boot_serial_out <= 1'b0;
      mem_cs_n_out    <= 1'b1;
    end else begin
      case (st_q)
        bootl_pkg::BOOTL_E_IDLE: begin
          div_q <= 8'h00;
          if (req_edge) begin
            st_q         <= bootl_pkg::BOOTL_E_LOW;
            mem_cs_n_out <= 1'b0; // R3
            if (mem_cs_n_out) begin
              tx_q            <= hdr_sel; // R4 R13
              boot_serial_out <= hdr_sel[31];
              bits_q          <= hdr_bits;
            end else begin
              tx_q            <= 32'h0;
              boot_serial_out <= 1'b0;
              bits_q          <= 6'h08;
            end
          end else if (!hold_s_q[1]) begin
            mem_cs_n_out <= 1'b1;
          end
        end
        bootl_pkg::BOOTL_E_LOW: begin
          div_q <= half_end ? 8'h00 : div_q + 8'h01;
          if (half_end) begin
            st_q          <= bootl_pkg::BOOTL_E_HIGH;
            boot_sclk_out <= 1'b1; // R1
          end
        end
        bootl_pkg::BOOTL_E_HIGH: begin
          div_q <= half_end ? 8'h00 : div_q + 8'h01;
          if (half_end) begin
            // Sample late in the high phase to cover synchroniser lag
            rx_q            <= {rx_q[6:0], din_s_q[1]};
            boot_sclk_out   <= 1'b0;
            tx_q            <= {tx_q[30:0], 1'b0};
            boot_serial_out <= tx_q[30]; // R1
            bits_q          <= bits_q - 6'h1;
            if (bits_q == 6'h1) begin
              st_q   <= bootl_pkg::BOOTL_E_IDLE;
              data_q <= {rx_q[6:0], din_s_q[1]};
              ack_q  <= ~ack_q;
            end else begin
              st_q <= bootl_pkg::BOOTL_E_LOW;
            end
          end
        end
        default: st_q <= bootl_pkg::BOOTL_E_IDLE;
      endcase
    end
  end
endmodule : bootl_spi_engine

// ---- bootl_loader.sv ----
// Operation
// R1: Drive serial clock and command/address line.
// R2: Capture memory data on separate input pin.
// R3: Hold chip select active during boot read.
// R4: Strap low 9-bit, high 16-bit addressing.
// R5: Board straps width pin with pull resistor.
// R6: Read first stored byte, decide load.
// R7: Marker b4 loads vendor, product, release IDs.
// R8: Marker d2 loads alternative microcontroller program.
// R9: Absent memory reads low, use ROM defaults.
// R10: Board without memory pulls data pin low.
// R11: Strap pin always has defined pull level.
// R12: Unknown marker: ignore memory, use ROM defaults.
// R13: Read command, zero address, sequential bytes.
`timescale 1ns/1ps
`include "bootl_consts.svh"
module bootl_loader #(
  parameter int CODE_AW = 14
) (
  // Clocks and reset
  input  wire logic               ref_clk_in,
  input  wire logic               link_clk_in,
  input  wire logic               resetn_in,
  // Board pins
  input  wire logic               addr_strap_in,
  input  wire logic               mem_data_in,
  output logic                    boot_sclk_out,
  output logic                    boot_serial_out,
  output logic                    mem_cs_n_out,
  // Boot outcome
  output logic                    boot_done_out,
  output logic                    use_ext_id_out,
  output logic                    use_ext_code_out,
  output logic                    rom_default_out,
  output logic [15:0]             vid_out,
  output logic [15:0]             pid_out,
  output logic [15:0]             rel_out,
  // Program store write port
  output logic                    code_we_out,
  output logic [CODE_AW-1:0]      code_addr_out,
  output logic [7:0]              code_data_out
);
  localparam int IW = CODE_AW + 2;

  bootl_link_if lnk ();

  bootl_spi_engine u_eng (
    .link_clk_in     (link_clk_in),
    .resetn_in       (resetn_in),
    .lnk             (lnk),
    .mem_data_in     (mem_data_in),
    .boot_sclk_out   (boot_sclk_out),
    .boot_serial_out (boot_serial_out),
    .mem_cs_n_out    (mem_cs_n_out)
  );

  bootl_pkg::bootl_state_t st_q;
  logic [1:0]    strap_s_q;
  logic [2:0]    ack_s_q;
  logic [1:0]    wait_q;
  logic          wide_q;
  logic          req_q;
  logic          hold_q;
  logic [7:0]    mark_q;
  logic [IW-1:0] idx_q;
  logic [15:0]   len_q;
  logic [7:0]    byte_q;

  assign lnk.req_tgl = req_q;
  assign lnk.hold    = hold_q;
  assign lnk.wide    = wide_q;

  // State and handshake decode
  wire           ack_edge  = ack_s_q[2] ^ ack_s_q[1];
  wire           in_idle   = (st_q == bootl_pkg::BOOTL_S_IDLE);
  wire           in_wait   = (st_q == bootl_pkg::BOOTL_S_WAIT);
  wire           in_eval   = (st_q == bootl_pkg::BOOTL_S_EVAL);
  wire           in_done   = (st_q == bootl_pkg::BOOTL_S_DONE);
  wire           strap_now = in_idle && (wait_q == 2'(`BOOTL_STRAP_WAIT));
  wire           take_byte = in_wait && ack_edge;
  wire           at_mark   = (idx_q == IW'(`BOOTL_IDX_MARK));
  // Record decode, meaningful once the marker is held
  wire           is_id     = (mark_q == `BOOTL_MARK_ID);
  wire           is_code   = (mark_q == `BOOTL_MARK_CODE);
  wire           mark_ok   = (byte_q == `BOOTL_MARK_ID) || (byte_q == `BOOTL_MARK_CODE);
  wire           at_len_lo = is_code && (idx_q == IW'(`BOOTL_IDX_LEN_LO));
  wire           at_len_hi = is_code && (idx_q == IW'(`BOOTL_IDX_LEN_HI));
  wire           at_code   = is_code && (idx_q >= IW'(`BOOTL_IDX_CODE0));
  wire [IW-1:0]  code_off  = idx_q - IW'(`BOOTL_IDX_CODE0);
  // Clamp keeps a corrupt length from running past the program store
  wire [IW-1:0]  len_lim   = (len_q > 16'(1 << CODE_AW)) ? IW'(1 << CODE_AW) : IW'(len_q);
  wire           code_last = at_code && ((code_off + IW'(1)) >= len_lim);
  wire           len_zero  = at_len_hi && ({byte_q, len_q[7:0]} == 16'h0000);
  wire           id_last   = is_id && (idx_q == IW'(`BOOTL_IDX_REL_HI));
  // Decisions on the byte under evaluation; absent memory reads zero
  wire           fin_rom   = in_eval && ((at_mark && !mark_ok) || len_zero); // R9 R12
  wire           fin_id    = in_eval && id_last; // R7
  wire           fin_code  = in_eval && code_last; // R8
  wire           finish    = fin_rom || fin_id || fin_code;
  wire           code_wr   = in_eval && at_code; // R8
  wire           ld_mark   = in_eval && at_mark; // R6
  wire           ld_len_lo = in_eval && at_len_lo;
  wire           ld_len_hi = in_eval && at_len_hi;

  // Strap passes two flops, then is held once sampled
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_s_q <= 2'h0;
      ack_s_q   <= 3'h0;
    end else begin
      strap_s_q <= {strap_s_q[0], addr_strap_in};
      ack_s_q   <= {ack_s_q[1:0], lnk.ack_tgl};
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q   <= bootl_pkg::BOOTL_S_IDLE;
      wait_q <= 2'h0;
      wide_q <= 1'b0;
      req_q  <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      case (st_q)
        bootl_pkg::BOOTL_S_IDLE: begin
          // Let the strap settle through its synchroniser first
          wait_q <= wait_q + 2'h1;
          if (strap_now) begin
            wide_q <= strap_s_q[1]; // R4
            hold_q <= 1'b1; // R3
            st_q   <= bootl_pkg::BOOTL_S_REQ;
          end
        end
        bootl_pkg::BOOTL_S_REQ: begin
          req_q <= ~req_q; // R13
          st_q  <= bootl_pkg::BOOTL_S_WAIT;
        end
        bootl_pkg::BOOTL_S_WAIT: begin
          if (take_byte) begin
            st_q <= bootl_pkg::BOOTL_S_EVAL;
          end
        end
        bootl_pkg::BOOTL_S_EVAL: begin
          st_q <= finish ? bootl_pkg::BOOTL_S_DONE : bootl_pkg::BOOTL_S_REQ;
        end
        bootl_pkg::BOOTL_S_DONE: begin
          // Dropping hold lets the engine release select
          hold_q <= 1'b0;
        end
        default: begin
          st_q <= bootl_pkg::BOOTL_S_IDLE;
        end
      endcase
    end
  end

  // Byte register and position in the record
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      byte_q <= 8'h00;
      mark_q <= 8'h00;
      idx_q  <= '0;
      len_q  <= 16'h0000;
    end else begin
      if (take_byte) begin
        byte_q <= lnk.data; // R6
      end
      if (in_eval) begin
        idx_q <= idx_q + IW'(1);
      end
      if (ld_mark) begin
        mark_q <= byte_q; // R6
      end
      if (ld_len_lo) begin
        len_q[7:0] <= byte_q;
      end
      if (ld_len_hi) begin
        len_q[15:8] <= byte_q;
      end
    end
  end

  // Outcome flags stand until the next reset
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boot_done_out    <= 1'b0;
      use_ext_id_out   <= 1'b0;
      use_ext_code_out <= 1'b0;
      rom_default_out  <= 1'b0;
    end else begin
      boot_done_out    <= boot_done_out | in_done;
      use_ext_id_out   <= use_ext_id_out | fin_id; // R7
      use_ext_code_out <= use_ext_code_out | fin_code; // R8
      rom_default_out  <= rom_default_out | fin_rom; // R9 R12
    end
  end

  // Program store write port, one pulse per byte
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      code_we_out   <= 1'b0;
      code_addr_out <= '0;
      code_data_out <= 8'h00;
    end else begin
      code_we_out <= code_wr; // R8
      if (code_wr) begin
        code_addr_out <= code_off[CODE_AW-1:0];
        code_data_out <= byte_q;
      end
    end
  end

  // One capture register per identity byte, in record order
  for (genvar g = 0; g < 6; g = g + 1) begin : g_id
    logic [7:0] b_q;
    wire        hit = in_eval && is_id && (idx_q == IW'(`BOOTL_IDX_VID_LO + g));
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        b_q <= 8'h00;
      end else if (hit) begin
        b_q <= byte_q; // R7
      end
    end
  end

  assign vid_out = {g_id[1].b_q, g_id[0].b_q};
  assign pid_out = {g_id[3].b_q, g_id[2].b_q};
  assign rel_out = {g_id[5].b_q, g_id[4].b_q};
endmodule : bootl_loader

// ---- bootl_loader_props.sv ----
`timescale 1ns/1ps
module bootl_loader_props #(
  parameter int CODE_AW = 14
) (
  // Clocks and memory pins
  input wire logic               ref_clk_in,
  input wire logic               link_clk_in,
  input wire logic               resetn_in,
  input wire logic               boot_sclk_out,
  input wire logic               boot_serial_out,
  input wire logic               mem_cs_n_out,
  // Outcome
  input wire logic               boot_done_out,
  input wire logic               use_ext_id_out,
  input wire logic               use_ext_code_out,
  input wire logic               rom_default_out,
  input wire logic [15:0]        vid_out,
  input wire logic [15:0]        pid_out,
  input wire logic [15:0]        rel_out,
  input wire logic               code_we_out,
  input wire logic [CODE_AW-1:0] code_addr_out
);
  logic               seen_q;
  logic [CODE_AW-1:0] last_q;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen_q <= 1'b0;
      last_q <= '0;
    end else if (code_we_out) begin
      seen_q <= 1'b1;
      last_q <= code_addr_out;
    end
  end
  sequence high_phase_s;
    boot_sclk_out [*8] ##[1:40] !boot_sclk_out;
  endsequence
  sclk_idle_a: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
    mem_cs_n_out |-> !boot_sclk_out) else $error("clock while deselected");
  sclk_high_a: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
    $rose(boot_sclk_out) |-> high_phase_s) else $error("bad clock high phase");
  cs_lead_a: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
    $rose(boot_sclk_out) |-> !$past(mem_cs_n_out, 8)) else $error("select too late");
  data_hold_a: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
    boot_sclk_out |-> $stable(boot_serial_out)) else $error("data moved in high phase");
  cs_release_a: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
    $rose(mem_cs_n_out) |-> boot_done_out) else $error("select dropped early");
  done_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    boot_done_out |=> boot_done_out) else $error("done fell");
  one_outcome_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(boot_done_out) |-> ##2 $onehot({use_ext_id_out, use_ext_code_out, rom_default_out}))
    else $error("outcome not unique");
  rom_ids_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    rom_default_out |-> vid_out == 16'h0 && pid_out == 16'h0 && rel_out == 16'h0) else $error("ids set");
  we_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    code_we_out |=> !code_we_out) else $error("write pulse too long");
  we_addr_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    code_we_out |-> code_addr_out == (seen_q ? last_q + 1'b1 : '0)) else $error("write address skip");
endmodule : bootl_loader_props
bind bootl_loader bootl_loader_props #(.CODE_AW(CODE_AW)) u_props (.ref_clk_in, .link_clk_in, .resetn_in,
  .boot_sclk_out, .boot_serial_out, .mem_cs_n_out, .boot_done_out, .use_ext_id_out, .use_ext_code_out,
  .rom_default_out, .vid_out, .pid_out, .rel_out, .code_we_out, .code_addr_out);

// ---- bootl_mem_model.sv ----
`timescale 1ns/1ps
module bootl_mem_model (
  // Memory pins
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  input  wire logic fitted_in,
  input  wire logic wide_in,
  output logic      so_out
);
  logic [7:0]  mem [0:63];
  logic [23:0] hdr_q;
  logic [15:0] base;
  logic        drv_q = 1'b0;
  int          bits_q;
  int          hbits;
  int          idx;
  assign hbits = wide_in ? 24 : 16;
  assign base = wide_in ? hdr_q[15:0] : {7'h0, hdr_q[11], hdr_q[7:0]};
  // Released line shows the inverse bit so stale data cannot pass
  assign so_out = !fitted_in ? 1'b0 : (cs_n_in ? ~drv_q : drv_q);
  always @(negedge cs_n_in) begin
    bits_q = 0;
    hdr_q = '0;
  end
  always @(posedge sclk_in) if (!cs_n_in) begin
    if (bits_q < hbits) hdr_q = {hdr_q[22:0], si_in};
    bits_q = bits_q + 1;
  end
  always @(negedge sclk_in) if (!cs_n_in && bits_q >= hbits) begin
    idx = bits_q - hbits;
    drv_q = mem[(base + idx / 8) % 64][7 - idx % 8];
  end
endmodule : bootl_mem_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk_in, link_clk_in, resetn_in, addr_strap_in, fitted, mem_data_in;
  logic        boot_sclk_out, boot_serial_out, mem_cs_n_out, boot_done_out, code_we_out;
  logic        use_ext_id_out, use_ext_code_out, rom_default_out;
  logic [15:0] vid_out, pid_out, rel_out;
  logic [13:0] code_addr_out;
  logic [7:0]  code_data_out;
  logic [7:0]  seen [0:15];
  int          n_we;
  int          err_count = 0;
  int          compares = 0;
  bootl_loader #(.CODE_AW(14)) DUT (.ref_clk_in, .link_clk_in, .resetn_in, .addr_strap_in, .mem_data_in,
    .boot_sclk_out, .boot_serial_out, .mem_cs_n_out, .boot_done_out, .use_ext_id_out, .use_ext_code_out,
    .rom_default_out, .vid_out, .pid_out, .rel_out, .code_we_out, .code_addr_out, .code_data_out);
  bootl_mem_model MEM (.sclk_in(boot_sclk_out), .cs_n_in(mem_cs_n_out), .si_in(boot_serial_out),
    .fitted_in(fitted), .wide_in(addr_strap_in), .so_out(mem_data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // Offset keeps link edges off the system edges
  initial begin
    link_clk_in = 1'b0;
    #1.3;
    forever #3 link_clk_in = ~link_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (!resetn_in) n_we <= 0;
    else if (code_we_out === 1'b1) begin
      seen[code_addr_out[3:0]] <= code_data_out;
      n_we <= n_we + 1;
    end
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic fill(input logic [63:0] v);
    for (int i = 0; i < 64; i++) MEM.mem[i] = (i < 8) ? v[63 - 8 * i -: 8] : 8'hee;
  endtask : fill
  task automatic boot(input logic strap, input logic fit);
    int i;
    @(negedge ref_clk_in);
    resetn_in = 1'b0;
    addr_strap_in = strap;
    fitted = fit;
    repeat (10) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    for (i = 0; i < 20000 && boot_done_out !== 1'b1; i++) @(negedge ref_clk_in);
    if (boot_done_out !== 1'b1) begin
      $display("mismatch boot_done_out expected 1 seen %b", boot_done_out);
      err_count++;
      finish_test();
    end
    repeat (100) @(negedge ref_clk_in);
  endtask : boot
  task automatic t_ids();
    fill(64'hb4_34_12_78_56_bc_9a_ee);
    boot(1'b1, 1'b1);
    check("header", 24'h030000, MEM.hdr_q);
    check("ext_id", 24'h1, use_ext_id_out);
    check("rom", 24'h0, rom_default_out);
    check("vid", 24'h1234, vid_out);
    check("pid", 24'h5678, pid_out);
    check("rel", 24'h9abc, rel_out);
    check("cs_n", 24'h1, mem_cs_n_out);
  endtask : t_ids
  task automatic t_code();
    fill(64'hd2_03_00_a1_b2_c3_99_ee);
    boot(1'b0, 1'b1);
    check("header", 24'h000300, MEM.hdr_q);
    check("ext_code", 24'h1, use_ext_code_out);
    check("rom", 24'h0, rom_default_out);
    check("we_count", 24'h3, n_we[23:0]);
    check("code0", 24'ha1, seen[0]);
    check("code1", 24'hb2, seen[1]);
    check("code2", 24'hc3, seen[2]);
  endtask : t_code
  task automatic t_nolen();
    fill(64'hd2_00_00_a1_b2_c3_99_ee);
    boot(1'b1, 1'b1);
    check("header", 24'h030000, MEM.hdr_q);
    check("rom", 24'h1, rom_default_out);
    check("ext_code", 24'h0, use_ext_code_out);
    check("we_count", 24'h0, n_we[23:0]);
  endtask : t_nolen
  task automatic t_unknown();
    fill(64'h5a_34_12_78_56_bc_9a_ee);
    boot(1'b1, 1'b1);
    check("rom", 24'h1, rom_default_out);
    check("ext_id", 24'h0, use_ext_id_out);
    check("vid", 24'h0, vid_out);
  endtask : t_unknown
  task automatic t_absent();
    fill(64'hd2_03_00_a1_b2_c3_99_ee);
    boot(1'b0, 1'b0);
    check("rom", 24'h1, rom_default_out);
    check("ext_code", 24'h0, use_ext_code_out);
    check("we_count", 24'h0, n_we[23:0]);
  endtask : t_absent
  initial begin
    resetn_in = 1'b0;
    addr_strap_in = 1'b0;
    fitted = 1'b0;
    t_ids();
    t_code();
    t_nolen();
    t_unknown();
    t_absent();
    finish_test();
  end
endmodule : tb_top
